// File: common/lia_defines.vh
`ifndef LIA_DEFINES_VH
`define LIA_DEFINES_VH

// ****************************************
// register bus geometry
// ****************************************
`define LIA_ADDR_W 12
`define LIA_DATA_W 32

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define LIA_OFF_ID 12'h020
`define LIA_OFF_TPR 12'h080
`define LIA_OFF_APR 12'h090
`define LIA_OFF_PPR 12'h0A0
`define LIA_OFF_EOI 12'h0B0
`define LIA_OFF_LDR 12'h0D0
`define LIA_OFF_CTRL 12'h0F0
`define LIA_OFF_ISR 12'h100
`define LIA_OFF_TMR 12'h180
`define LIA_OFF_IRR 12'h200
`define LIA_OFF_STAT 12'h2F0

// ****************************************
// field positions and reset values
// ****************************************
`define LIA_CTRL_LEGACY_BIT 0
`define LIA_TPR_RESET 8'h00
`define LIA_ID_RESET 8'h00
`define LIA_LDR_RESET 8'h00
`define LIA_CTRL_RESET 1'b0

// ****************************************
// delivery modes on the message port
// ****************************************
`define LIA_MODE_FIXED 4'h0
`define LIA_MODE_LOWEST 4'h1
`define LIA_MODE_SYSMGMT 4'h2
`define LIA_MODE_NMI 4'h4
`define LIA_MODE_INIT 4'h5
`define LIA_MODE_STARTUP 4'h6
`define LIA_MODE_EXTLEGACY 4'h7
`define LIA_MODE_INIT_DEASSERT 4'h8
`define LIA_MODE_BOOTSTRAP 4'h9
`define LIA_MODE_FINAL 4'hA

// ****************************************
// vector and destination constants
// ****************************************
`define LIA_BCAST_DEST 8'hFF
`define LIA_MIN_CLASS 4'h1
`define LIA_SLOTS_PER_CLASS 2'h2

`endif

// File: src/lia_prio_enc.v
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// highest set bit finder
// ****************************************
module lia_prio_enc #(
  parameter WIDTH = 256,
  parameter IDX_W = 8
) (
  // bit vector in
  input wire [WIDTH-1:0] bits_i,
  // highest set index, zero when none
  output reg [IDX_W-1:0] index_o,
  output reg any_o
);

  integer i;

  // last set bit seen on an ascending walk is the highest
  always @* begin
    index_o = {IDX_W{1'b0}};
    any_o = 1'b0;
    for (i = 0; i < WIDTH; i = i + 1) begin
      if (bits_i[i]) begin
        index_o = i[IDX_W-1:0];
        any_o = 1'b1;
      end
    end
  end

endmodule // lia_prio_enc

`default_nettype wire

// File: src/lia_prio_calc.v
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// processor and arbitration priority
// ****************************************
module lia_prio_calc (
  // priority sources
  input wire [7:0] tpr_i,
  input wire [7:0] highest_in_service_vector_i,
  input wire [7:0] irrv_i,
  // computed priorities
  output reg [7:0] ppr_o,
  output reg [7:0] apr_o
);

  reg [3:0] tpr_and_isr;

  // pure logic so any change of threshold or in-service bits shows at once
  always @* begin
    if (tpr_i[7:4] >= highest_in_service_vector_i[7:4]) begin
      ppr_o = tpr_i;
    end else begin
      ppr_o = {highest_in_service_vector_i[7:4], 4'h0};
    end
  end

  // threshold also feeds the lowest-priority arbitration value
  always @* begin
    tpr_and_isr = tpr_i[7:4] & highest_in_service_vector_i[7:4];
    if ((tpr_i[7:4] >= irrv_i[7:4]) && (tpr_i[7:4] > highest_in_service_vector_i[7:4])) begin
      apr_o = tpr_i;
    end else if (tpr_and_isr > irrv_i[7:4]) begin
      apr_o = {tpr_and_isr, 4'h0};
    end else begin
      apr_o = {irrv_i[7:4], 4'h0};
    end
  end

endmodule // lia_prio_calc

`default_nettype wire

// File: src/lia_acceptance.v
`timescale 1ns/100ps
`default_nettype none
`include "lia_defines.vh"

module lia_acceptance #(
  parameter NVEC = 256
) (
  // clock and reset
  input wire ref_clk_i,
  input wire reset_n_i,
  // register port
  input wire [`LIA_ADDR_W-1:0] reg_addr_i,
  input wire [`LIA_DATA_W-1:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output wire [`LIA_DATA_W-1:0] reg_rdata_o,
  // incoming interrupt messages
  input wire msg_valid_i,
  input wire [7:0] msg_vector_i,
  input wire [3:0] msg_mode_i,
  input wire msg_level_i,
  input wire [7:0] msg_dest_i,
  input wire msg_dest_logical_i,
  input wire msg_arb_won_i,
  output wire msg_accept_o,
  output wire msg_retry_o,
  output wire [7:0] arb_priority_o,
  // fixed interrupt dispatch to the core
  input wire core_ready_i,
  output wire core_int_valid_o,
  output wire [7:0] core_int_vector_o,
  // special deliveries to the core
  output wire core_spec_valid_o,
  output wire [3:0] core_spec_mode_o,
  output wire [7:0] core_spec_vector_o,
  // completion message to the bus
  output wire eoi_msg_valid_o,
  output wire [7:0] eoi_msg_vector_o
);

  // ****************************************
  // state
  // ****************************************
  // one bit per vector in each of the three banks
  reg [NVEC-1:0] irr_r;
  reg [NVEC-1:0] isr_r;
  reg [NVEC-1:0] tmr_r;
  reg [NVEC-1:0] irr_nxt;
  reg [NVEC-1:0] isr_nxt;
  reg [NVEC-1:0] tmr_nxt;
  reg [7:0] tpr_r;
  reg [7:0] id_r;
  reg [7:0] ldr_r;
  reg legacy_r;
  reg [7:0] apr_r;
  reg [`LIA_DATA_W-1:0] rdata_r;
  reg int_valid_r;
  reg [7:0] int_vector_r;
  reg spec_valid_r;
  reg [3:0] spec_mode_r;
  reg [7:0] spec_vector_r;
  reg eoi_valid_r;
  reg [7:0] eoi_vector_r;

  // highest set vectors and the priorities derived from them
  wire [7:0] irrv;
  wire [7:0] highest_in_service_vector;
  wire irr_any;
  wire isr_any;
  wire [7:0] processor_priority_value;
  wire [7:0] apr;

  // ****************************************
  // priority helpers
  // ****************************************
  lia_prio_enc #(
    .WIDTH(NVEC),
    .IDX_W(8)
  ) u_irr_enc (
    .bits_i(irr_r),
    .index_o(irrv),
    .any_o(irr_any)
  );

  lia_prio_enc #(
    .WIDTH(NVEC),
    .IDX_W(8)
  ) u_isr_enc (
    .bits_i(isr_r),
    .index_o(highest_in_service_vector), // zero when nothing is in service
    .any_o(isr_any)
  );

  lia_prio_calc u_calc (
    .tpr_i(tpr_r),
    .highest_in_service_vector_i(highest_in_service_vector),
    .irrv_i(irrv),
    .ppr_o(processor_priority_value), // recomputed with no register in the path
    .apr_o(apr)
  );

  // ****************************************
  // message acceptance
  // ****************************************
  // destination match is pure logic so accept and retry answer in the message cycle;
  // logical mode matches when any destination bit hits the logical id
  wire [3:0] msg_class = msg_vector_i[7:4]; // class is the vector over sixteen
  wire phys_hit = (msg_dest_i == id_r) || (msg_dest_i == `LIA_BCAST_DEST);
  wire logi_hit = |(msg_dest_i & ldr_r);
  wire addressed = msg_valid_i && (msg_dest_logical_i ? logi_hit : phys_hit);

  reg is_special;
  reg is_queued;
  // mode sorting; protocol messages only exist on the older variant
  always @* begin
    is_special = 1'b0;
    is_queued = 1'b0;
    case (msg_mode_i)
      `LIA_MODE_NMI, `LIA_MODE_SYSMGMT, `LIA_MODE_INIT,
      `LIA_MODE_STARTUP, `LIA_MODE_EXTLEGACY: begin
        is_special = 1'b1;
      end
      `LIA_MODE_INIT_DEASSERT, `LIA_MODE_BOOTSTRAP, `LIA_MODE_FINAL: begin
        is_special = legacy_r;
      end
      `LIA_MODE_FIXED, `LIA_MODE_LOWEST: begin
        is_queued = 1'b1;
      end
      default: begin
        is_queued = 1'b0;
      end
    endcase
  end

  // ****************************************
  // older variant slot check
  // ****************************************
  // older variant: count occupied slots of this class over both queues;
  // the count saturates at two, which is all the retry decision needs
  wire [15:0] irr_cls = irr_r[{msg_class, 4'h0} +: 16];
  wire [15:0] isr_cls = isr_r[{msg_class, 4'h0} +: 16];
  reg [1:0] slots_used;
  integer k;
  always @* begin
    slots_used = 2'h0;
    for (k = 0; k < 16; k = k + 1) begin
      if ((irr_cls[k] || isr_cls[k]) && (slots_used != `LIA_SLOTS_PER_CLASS)) begin
        slots_used = slots_used + 2'h1;
      end
    end
  end

  // vectors in class 0 are reserved and never queued
  wire vec_ok = (msg_class >= `LIA_MIN_CLASS);
  // older variant: a lost lowest-priority arbitration means it is not ours
  wire arb_ok = !legacy_r || (msg_mode_i != `LIA_MODE_LOWEST) || msg_arb_won_i;
  wire queue_cand = addressed && is_queued && vec_ok && arb_ok;
  wire slot_free = (slots_used != `LIA_SLOTS_PER_CLASS) && !irr_r[msg_vector_i];
  wire fixed_take = queue_cand && (!legacy_r || slot_free);
  wire special_take = addressed && is_special; // bypasses threshold entirely

  assign msg_retry_o = queue_cand && legacy_r && !slot_free;
  assign msg_accept_o = fixed_take || special_take;

  // ****************************************
  // dispatch and end of interrupt
  // ****************************************
  // dispatch reads processor priority from the comb path, so a threshold write
  // or an end write takes effect on the very next edge with no stale cycle
  wire eoi_wr = reg_wr_i && (reg_addr_i == `LIA_OFF_EOI);
  // pending class must beat processor class, so threshold 15 stops all
  wire dispatch = irr_any && (irrv[7:4] > processor_priority_value[7:4]) && core_ready_i;
  // an end write with nothing in service is ignored and raises no completion
  wire eoi_hit = eoi_wr && isr_any;

  // per-vector update; a new request wins over a same-cycle dispatch clear
  genvar g;
  generate
    for (g = 0; g < NVEC; g = g + 1) begin : g_vec
      wire acc_g = fixed_take && (msg_vector_i == g);
      wire disp_g = dispatch && (irrv == g);
      wire eoi_g = eoi_hit && (highest_in_service_vector == g);
      always @* begin
        irr_nxt[g] = acc_g || (irr_r[g] && !disp_g);
        isr_nxt[g] = disp_g || (isr_r[g] && !eoi_g);
        tmr_nxt[g] = acc_g ? msg_level_i : tmr_r[g];
      end
    end
  endgenerate

  // queue registers
  // everything resets to empty so no stale request survives a reset
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irr_r <= {NVEC{1'b0}};
      isr_r <= {NVEC{1'b0}};
      tmr_r <= {NVEC{1'b0}};
    end else begin
      irr_r <= irr_nxt;
      isr_r <= isr_nxt;
      tmr_r <= tmr_nxt;
    end
  end

  // core and bus notifications, one-cycle pulses
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      int_valid_r <= 1'b0;
      int_vector_r <= 8'h00;
      spec_valid_r <= 1'b0;
      spec_mode_r <= 4'h0;
      spec_vector_r <= 8'h00;
      eoi_valid_r <= 1'b0;
      eoi_vector_r <= 8'h00;
      apr_r <= 8'h00;
    end else begin
      int_valid_r <= dispatch;
      if (dispatch) begin
        int_vector_r <= irrv;
      end
      spec_valid_r <= special_take;
      if (special_take) begin
        spec_mode_r <= msg_mode_i;
        spec_vector_r <= msg_vector_i;
      end
      eoi_valid_r <= eoi_hit && tmr_r[highest_in_service_vector]; // level-triggered only
      if (eoi_hit) begin
        eoi_vector_r <= highest_in_service_vector;
      end
      apr_r <= apr;
    end
  end

  // ****************************************
  // register port
  // ****************************************
  // writable configuration; processor priority has no write path
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tpr_r <= `LIA_TPR_RESET;
      id_r <= `LIA_ID_RESET;
      ldr_r <= `LIA_LDR_RESET;
      legacy_r <= `LIA_CTRL_RESET;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `LIA_OFF_TPR) begin
        tpr_r <= reg_wdata_i[7:0];
      end else if (reg_addr_i == `LIA_OFF_ID) begin
        id_r <= reg_wdata_i[7:0];
      end else if (reg_addr_i == `LIA_OFF_LDR) begin
        ldr_r <= reg_wdata_i[7:0];
      end else if (reg_addr_i == `LIA_OFF_CTRL) begin
        legacy_r <= reg_wdata_i[`LIA_CTRL_LEGACY_BIT];
      end
    end
  end

  // ****************************************
  // read data
  // ****************************************
  // bank base addresses; only bits 11:7 select a bank
  localparam [11:0] ISR_BASE = `LIA_OFF_ISR;
  localparam [11:0] TMR_BASE = `LIA_OFF_TMR;
  localparam [11:0] IRR_BASE = `LIA_OFF_IRR;

  // bank decode: eight words per 256-bit bank, 16 bytes apart
  wire [2:0] word = reg_addr_i[6:4];
  wire low_ok = (reg_addr_i[3:0] == 4'h0);
  wire in_isr = low_ok && (reg_addr_i[11:7] == ISR_BASE[11:7]);
  wire in_tmr = low_ok && (reg_addr_i[11:7] == TMR_BASE[11:7]);
  wire in_irr = low_ok && (reg_addr_i[11:7] == IRR_BASE[11:7]);

  // read data stand for exactly one cycle; unmapped reads give zero
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (!reg_rd_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (reg_addr_i == `LIA_OFF_TPR) begin
      rdata_r <= {24'h00_0000, tpr_r};
    end else if (reg_addr_i == `LIA_OFF_PPR) begin
      rdata_r <= {24'h00_0000, processor_priority_value};
    end else if (reg_addr_i == `LIA_OFF_APR) begin
      rdata_r <= {24'h00_0000, apr_r};
    end else if (reg_addr_i == `LIA_OFF_ID) begin
      rdata_r <= {24'h00_0000, id_r};
    end else if (reg_addr_i == `LIA_OFF_LDR) begin
      rdata_r <= {24'h00_0000, ldr_r};
    end else if (reg_addr_i == `LIA_OFF_CTRL) begin
      rdata_r <= {31'h0000_0000, legacy_r};
    end else if (reg_addr_i == `LIA_OFF_STAT) begin
      rdata_r <= {14'h0000, isr_any, irr_any, highest_in_service_vector, irrv};
    end else if (in_isr) begin
      rdata_r <= isr_r[{word, 5'h00} +: 32];
    end else if (in_tmr) begin
      rdata_r <= tmr_r[{word, 5'h00} +: 32];
    end else if (in_irr) begin
      rdata_r <= irr_r[{word, 5'h00} +: 32];
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // registered values drive the pins directly; no logic sits behind the output flops
  assign reg_rdata_o = rdata_r;
  assign arb_priority_o = apr_r;
  assign core_int_valid_o = int_valid_r;
  assign core_int_vector_o = int_vector_r;
  assign core_spec_valid_o = spec_valid_r;
  assign core_spec_mode_o = spec_mode_r;
  assign core_spec_vector_o = spec_vector_r;
  assign eoi_msg_valid_o = eoi_valid_r;
  assign eoi_msg_vector_o = eoi_vector_r;

endmodule // lia_acceptance

`default_nettype wire

// File: sim/lia_acc_checker_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// port checker for the acceptance block
// ****************************************
module lia_acc_checker (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // register port
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // message port
  input wire logic msg_valid_i,
  input wire logic [7:0] msg_vector_i,
  input wire logic [3:0] msg_mode_i,
  input wire logic msg_accept_o,
  input wire logic msg_retry_o,
  // core and bus side
  input wire logic core_ready_i,
  input wire logic core_int_valid_o,
  input wire logic [7:0] core_int_vector_o,
  input wire logic core_spec_valid_o,
  input wire logic [3:0] core_spec_mode_o,
  input wire logic [7:0] core_spec_vector_o,
  input wire logic eoi_msg_valid_o
);
  logic [7:0] tpr_q;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // shadow of the threshold, so gating is judged against what software wrote
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) tpr_q <= 8'h00;
    else if (reg_wr_i && reg_addr_i == 12'h080) tpr_q <= reg_wdata_i[7:0];
  end
  property p_idle; !msg_valid_i |-> !msg_accept_o && !msg_retry_o; endproperty
  a_idle: assert property (p_idle) else $error("answer without a message");
  property p_spec; msg_valid_i && msg_accept_o && msg_mode_i inside {4'h2, 4'h4, 4'h5, 4'h6, 4'h7} |=>
    core_spec_valid_o && core_spec_mode_o == $past(msg_mode_i) && core_spec_vector_o == $past(msg_vector_i); endproperty
  a_spec: assert property (p_spec) else $error("special delivery not passed on");
  property p_fixed; msg_valid_i && msg_accept_o && msg_mode_i == 4'h0 |=> !core_spec_valid_o; endproperty
  a_fixed: assert property (p_fixed) else $error("fixed vector sent as special");
  property p_retry; msg_retry_o |-> !msg_accept_o && msg_mode_i inside {4'h0, 4'h1}; endproperty
  a_retry: assert property (p_retry) else $error("retry on wrong message");
  property p_ready; core_int_valid_o |-> $past(core_ready_i); endproperty
  a_ready: assert property (p_ready) else $error("dispatch while core busy");
  property p_gate; core_int_valid_o |-> core_int_vector_o[7:4] > $past(tpr_q[7:4]); endproperty
  a_gate: assert property (p_gate) else $error("dispatch at or below threshold");
  property p_eoi; eoi_msg_valid_o |-> $past(reg_wr_i && reg_addr_i == 12'h0B0); endproperty
  a_eoi: assert property (p_eoi) else $error("completion without end write");
  property p_ppr; $past(reg_rd_i && reg_addr_i == 12'h0A0) |-> reg_rdata_o[31:8] == 24'h000000 &&
    (reg_rdata_o[7:0] == $past(tpr_q) || (reg_rdata_o[7:4] > $past(tpr_q[7:4]) && reg_rdata_o[3:0] == 4'h0)); endproperty
  a_ppr: assert property (p_ppr) else $error("processor priority wrong");
  c_disp: cover property (core_int_valid_o);
  c_retry: cover property (msg_retry_o);
  c_eoi: cover property (eoi_msg_valid_o);
endmodule // lia_acc_checker
bind lia_acceptance lia_acc_checker u_chk (.ref_clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .msg_valid_i, .msg_vector_i, .msg_mode_i, .msg_accept_o, .msg_retry_o, .core_ready_i,
  .core_int_valid_o, .core_int_vector_o, .core_spec_valid_o, .core_spec_mode_o, .core_spec_vector_o, .eoi_msg_valid_o);
`default_nettype wire

// File: sim/lia_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// processor core stand-in
// ****************************************
module lia_core_model (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // bench keeps the core busy
  input wire logic hold_i,
  // dispatch from the controller
  input wire logic core_int_valid_i,
  output wire logic core_ready_o
);
  logic taking_r;
  // entering a handler costs a cycle, so back-to-back dispatch is not always offered
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) taking_r <= 1'b0;
    else taking_r <= core_int_valid_i;
  end
  assign core_ready_o = reset_n_i && !hold_i && !taking_r;
endmodule // lia_core_model
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic ref_clk_i, reset_n_i, reg_wr_i, reg_rd_i, msg_valid_i, msg_level_i, msg_dest_logical_i, msg_arb_won_i, hold;
  logic [11:0] reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic [7:0] msg_vector_i, msg_dest_i;
  logic [3:0] msg_mode_i;
  logic [3:0] modes [8] = '{4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA};
  wire [31:0] reg_rdata_o;
  wire [7:0] arb_priority_o, core_int_vector_o, core_spec_vector_o, eoi_msg_vector_o;
  wire [3:0] core_spec_mode_o;
  wire msg_accept_o, msg_retry_o, core_ready_i, core_int_valid_o, core_spec_valid_o, eoi_msg_valid_o;
  int n_fail, comparisons, k;
  lia_acceptance dut (.ref_clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .msg_valid_i, .msg_vector_i, .msg_mode_i, .msg_level_i, .msg_dest_i, .msg_dest_logical_i, .msg_arb_won_i,
    .msg_accept_o, .msg_retry_o, .arb_priority_o, .core_ready_i, .core_int_valid_o, .core_int_vector_o,
    .core_spec_valid_o, .core_spec_mode_o, .core_spec_vector_o, .eoi_msg_valid_o, .eoi_msg_vector_o);
  lia_core_model u_core (.ref_clk_i, .reset_n_i, .hold_i(hold), .core_int_valid_i(core_int_valid_o),
    .core_ready_o(core_ready_i));
  // ****************************************
  // shared tasks
  // ****************************************
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, e);
  endtask
  // one message pulse; accept and retry are combinational, special pulse follows
  task msg(input logic [7:0] v, input logic [3:0] m, input logic [7:0] dst, input logic lvl, input logic arb,
      input logic acc, input logic rty, input logic spec);
    @(posedge ref_clk_i);
    msg_vector_i <= v;
    msg_mode_i <= m;
    msg_dest_i <= dst;
    msg_level_i <= lvl;
    msg_arb_won_i <= arb;
    msg_valid_i <= 1'b1;
    #1;
    chk(msg_accept_o, acc);
    chk(msg_retry_o, rty);
    @(posedge ref_clk_i);
    msg_valid_i <= 1'b0;
    #1;
    chk(core_spec_valid_o, spec);
    if (spec) begin
      chk(core_spec_mode_o, m);
      chk(core_spec_vector_o, v);
    end
  endtask
  // bounded wait for a dispatch pulse, then compare its vector
  task waitint(input logic [7:0] v);
    int i;
    i = 0;
    do begin
      @(posedge ref_clk_i);
      #1;
      i++;
    end while (core_int_valid_o !== 1'b1 && i < 60);
    if (core_int_valid_o !== 1'b1) begin
      n_fail++;
      print_verdict;
    end else begin
      chk(core_int_vector_o, v);
    end
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    #2000000;
    n_fail++;
    print_verdict;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {reset_n_i, reg_wr_i, reg_rd_i, msg_valid_i, msg_level_i, msg_dest_logical_i, msg_arb_won_i} = 7'h00;
    {reg_addr_i, reg_wdata_i, msg_vector_i, msg_dest_i, msg_mode_i} = 64'h0;
    hold = 1'b1;
    repeat (10) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    rd(12'h0A0, 32'h0);
    wr(12'h080, 32'h35);
    rd(12'h080, 32'h35);
    rd(12'h0A0, 32'h35);
    wr(12'h0A0, 32'hFF);
    rd(12'h0A0, 32'h35);
    rd(12'h3F0, 32'h0);
    wr(12'h080, 32'h00);
    $display("test registers done");
    msg(8'h45, 4'h0, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    msg(8'h47, 4'h0, 8'h00, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    msg(8'h55, 4'h0, 8'h05, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    msg(8'h0F, 4'h0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    rd(12'h220, 32'hA0);
    rd(12'h1A0, 32'h80);
    @(posedge ref_clk_i) hold <= 1'b0;
    waitint(8'h47);
    rd(12'h220, 32'h20);
    rd(12'h0A0, 32'h40);
    rd(12'h090, 32'h40);
    chk(arb_priority_o, 8'h40);
    msg(8'h62, 4'h0, 8'hFF, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    waitint(8'h62);
    rd(12'h0A0, 32'h60);
    wr(12'h0B0, 32'h0);
    chk(eoi_msg_valid_o, 1'b0);
    rd(12'h220, 32'h20);
    wr(12'h0B0, 32'h0);
    chk(eoi_msg_valid_o, 1'b1);
    chk(eoi_msg_vector_o, 8'h47);
    waitint(8'h45);
    wr(12'h0B0, 32'h0);
    $display("test dispatch done");
    wr(12'h080, 32'hF0);
    msg(8'hE5, 4'h0, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    for (k = 0; k < 8; k++) begin
      msg(8'h20 + k, modes[k], 8'h00, 1'b0, 1'b0, k < 5, 1'b0, k < 5);
      chk(core_int_valid_o, 1'b0);
    end
    wr(12'h080, 32'h00);
    waitint(8'hE5);
    wr(12'h0B0, 32'h0);
    $display("test threshold done");
    wr(12'h080, 32'hF0);
    wr(12'h0F0, 32'h1);
    msg(8'h81, 4'h0, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    msg(8'h82, 4'h0, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    msg(8'h83, 4'h0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    msg(8'h91, 4'h1, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    msg(8'h91, 4'h1, 8'h00, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    rd(12'h240, 32'h00020006);
    chk(arb_priority_o, 8'hF0);
    for (k = 5; k < 8; k++) begin
      msg(8'h30, modes[k], 8'h00, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    end
    $display("test older variant done");
    // own id and logical id other than zero, physical then logical matching
    wr(12'h020, 32'h03);
    wr(12'h0D0, 32'h04);
    rd(12'h020, 32'h03);
    msg(8'h21, 4'h4, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    msg(8'h22, 4'h4, 8'h03, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    @(posedge ref_clk_i) msg_dest_logical_i <= 1'b1;
    msg(8'h23, 4'h4, 8'h06, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    msg(8'h24, 4'h4, 8'h08, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    $display("test destination done");
    print_verdict;
  end
endmodule // testbench
`default_nettype wire
